/* hw/ready_pulse_defines.svh */
`ifndef READY_PULSE_DEFINES_SVH
`define READY_PULSE_DEFINES_SVH

// Prescale select codes
`define PRESCALE_DIV1 2'h0
`define PRESCALE_DIV2 2'h1
`define PRESCALE_DIV4 2'h2
`define PRESCALE_DIV8 2'h3
`define PRESCALE_RESET 2'h0

// Analog sample clock cycles per digital sample clock period
`define ANALOG_PER_SAMPLE 4'h4
// Analog sample clock cycles in the pulse low time
`define PULSE_ANALOG_CYCLES 4'h2

// Oversampling ratio field and reset value
`define OSR_SEL_RESET 3'h3
`define OSR_MIN 13'h0020

`define DRIVE_SELECT_RESET 1'h0

`endif

/* hw/ready_pulse_pkg.sv */
package ready_pulse_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PULSE
    } strobe_state_t;
endpackage

/* hw/sample_tick_if.sv */
interface sample_tick_if;
    logic analog_tick;
    logic sample_tick;
    logic [3:0] analog_phase;
    modport src (output analog_tick, output sample_tick, output analog_phase);
    modport dst (input analog_tick, input sample_tick, input analog_phase);
endinterface

/* hw/sample_clock_div.sv */
`include "ready_pulse_defines.svh"

module sample_clock_div (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Setting
    input wire logic [1:0] prescale_sel_i,
    // Ticks
    sample_tick_if.src tick
);
    logic [2:0] pre_cnt_reg;
    logic [3:0] phase_reg;
    logic [2:0] pre_last;
    logic analog_tick_w;

    function automatic logic [2:0] prescale_last(input logic [1:0] sel);
        case (sel)
            `PRESCALE_DIV1: prescale_last = 3'h0;
            `PRESCALE_DIV2: prescale_last = 3'h1;
            `PRESCALE_DIV4: prescale_last = 3'h3;
            default: prescale_last = 3'h7;
        endcase
    endfunction

    // Analog sample clock is master clock over prescale
    assign pre_last = prescale_last(prescale_sel_i);
    // Greater-or-equal so a smaller prescale set mid-count wraps at once
    assign analog_tick_w = (pre_cnt_reg >= pre_last);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_cnt_reg <= 3'h0;
        end else if (ce_i) begin
            pre_cnt_reg <= analog_tick_w ? 3'h0 : pre_cnt_reg + 3'h1;
        end
    end

    // Digital sample clock is analog sample clock over four
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_reg <= 4'h0;
        end else if (ce_i && analog_tick_w) begin
            phase_reg <= (phase_reg == `ANALOG_PER_SAMPLE - 4'h1) ? 4'h0 : phase_reg + 4'h1;
        end
    end

    assign tick.analog_tick = ce_i && analog_tick_w;
    assign tick.sample_tick = ce_i && analog_tick_w && (phase_reg == `ANALOG_PER_SAMPLE - 4'h1);
    assign tick.analog_phase = phase_reg;
endmodule

/* hw/conversion_ready_pulse_gen.sv */
`include "ready_pulse_defines.svh"

// Notes on behaviour
// - Drive select 1 drives pin high when idle; 0 (reset) leaves it floating.
// - One active-low pulse on the ready pin per finished conversion.
// - Pulse is synchronous to the master clock, always the same width.
// - Low time is exactly half a digital sample clock period.
// - Pulses repeat at the output rate, one per output data period.
// - No latched level; timing set only by clock, oversampling and prescale.
// - Serial port activity never gates, delays or clears the pulse.
// - Digital sample clock is master clock over prescale, then over four.
// - Output rate is digital sample clock divided by oversampling ratio.
// - Prescale codes 00..11 divide by 1, 2, 4, 8; reset is 00.
module conversion_ready_pulse_gen #(
    parameter int OSR_W = 13
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Configuration
    input wire logic ready_pin_drive_select_i,
    input wire logic [1:0] prescale_sel_i,
    input wire logic [2:0] osr_sel_i,
    // Ready pin
    output logic conversion_ready_strobe_n_o,
    output logic conversion_ready_strobe_oe_o,
    // Status
    output logic output_rate_clock_o
);
    sample_tick_if tick ();

    logic [1:0] prescale_reg;
    logic [OSR_W-1:0] osr_cnt_reg;
    logic [OSR_W-1:0] osr_last;
    logic [3:0] width_cnt_reg;
    ready_pulse_pkg::strobe_state_t state_reg;
    logic window_end;
    logic pulse_hold;

    function automatic logic [OSR_W-1:0] osr_ratio_last(input logic [2:0] sel);
        osr_ratio_last = OSR_W'((`OSR_MIN << sel) - 13'h0001);
    endfunction

    sample_clock_div u_div (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .prescale_sel_i(prescale_reg),
        .tick(tick)
    );

    // Prescale held through a pulse so every pulse keeps the same width
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prescale_reg <= `PRESCALE_RESET;
        end else if (ce_i && (tick.sample_tick || state_reg == ready_pulse_pkg::ST_IDLE)) begin
            prescale_reg <= prescale_sel_i;
        end
    end

    // Oversampling window counter; no serial input reaches it
    assign osr_last = osr_ratio_last(osr_sel_i);
    assign window_end = tick.sample_tick && (osr_cnt_reg >= osr_last);

    // Pulse continues unless its last analog tick arrives now
    assign pulse_hold = (state_reg == ready_pulse_pkg::ST_PULSE) &&
        !(tick.analog_tick && width_cnt_reg == `PULSE_ANALOG_CYCLES - 4'h1);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osr_cnt_reg <= '0;
        end else if (ce_i && tick.sample_tick) begin
            osr_cnt_reg <= (osr_cnt_reg >= osr_last) ? '0 : osr_cnt_reg + OSR_W'(1);
        end
    end

    // Pulse state: starts at each window end, ends after two analog cycles
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ready_pulse_pkg::ST_IDLE;
            width_cnt_reg <= 4'h0;
        end else if (ce_i) begin
            case (state_reg)
                ready_pulse_pkg::ST_IDLE: begin
                    if (window_end) begin
                        state_reg <= ready_pulse_pkg::ST_PULSE;
                        width_cnt_reg <= 4'h0;
                    end
                end
                ready_pulse_pkg::ST_PULSE: begin
                    if (tick.analog_tick) begin
                        if (width_cnt_reg == `PULSE_ANALOG_CYCLES - 4'h1) begin
                            state_reg <= ready_pulse_pkg::ST_IDLE;
                        end
                        width_cnt_reg <= width_cnt_reg + 4'h1;
                    end
                end
                default: state_reg <= ready_pulse_pkg::ST_IDLE;
            endcase
        end
    end

    // Pin outputs are registered copies of the pulse state; low is driven,
    // idle level high or released per drive select
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            conversion_ready_strobe_n_o <= 1'h1;
            conversion_ready_strobe_oe_o <= `DRIVE_SELECT_RESET;
        end else if (ce_i) begin
            conversion_ready_strobe_n_o <= !(window_end || pulse_hold);
            conversion_ready_strobe_oe_o <= ready_pin_drive_select_i || window_end || pulse_hold;
        end
    end

    // Output rate clock: toggles once per window, for observation
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            output_rate_clock_o <= 1'h0;
        end else if (ce_i && window_end) begin
            output_rate_clock_o <= !output_rate_clock_o;
        end
    end

    // Enabled master cycles per sample and per low pulse, counted apart from the
    // divider so the checks below do not reuse its logic
    logic [5:0] sample_gap_reg;
    logic [1:0] gap_prescale_reg;
    logic gap_valid_reg;
    logic [5:0] low_len_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sample_gap_reg <= 6'h00;
            gap_prescale_reg <= `PRESCALE_RESET;
            gap_valid_reg <= 1'h0;
        end else if (ce_i) begin
            gap_prescale_reg <= prescale_reg;
            if (tick.sample_tick) begin
                sample_gap_reg <= 6'h00;
                gap_valid_reg <= 1'h1;
            end else begin
                sample_gap_reg <= sample_gap_reg + 6'h01;
                if (gap_prescale_reg != prescale_reg) begin
                    gap_valid_reg <= 1'h0;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_len_reg <= 6'h00;
        end else if (ce_i) begin
            low_len_reg <= conversion_ready_strobe_n_o ? 6'h00 : low_len_reg + 6'h01;
        end
    end

    // Pulse stays low exactly until the second analog tick inside it
    property p_pulse_ends;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == ready_pulse_pkg::ST_PULSE && tick.analog_tick &&
         width_cnt_reg == 4'h1) |=> conversion_ready_strobe_n_o;
    endproperty
    a_pulse_ends: assert property (p_pulse_ends) else $error("pulse too long");

    property p_window_starts;
        @(posedge clk_i) disable iff (!rst_n_i)
        window_end |=> !conversion_ready_strobe_n_o && conversion_ready_strobe_oe_o;
    endproperty
    a_window_starts: assert property (p_window_starts) else $error("no pulse at window");

    property p_idle_release;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && !ready_pin_drive_select_i && !window_end &&
         state_reg == ready_pulse_pkg::ST_IDLE) |=> !conversion_ready_strobe_oe_o;
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("idle pin driven");

    property p_idle_drive;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && ready_pin_drive_select_i) |=> conversion_ready_strobe_oe_o;
    endproperty
    a_idle_drive: assert property (p_idle_drive) else $error("pin not driven");

    property p_low_only_in_pulse;
        @(posedge clk_i) disable iff (!rst_n_i)
        !conversion_ready_strobe_n_o |-> state_reg == ready_pulse_pkg::ST_PULSE;
    endproperty
    a_low_only_in_pulse: assert property (p_low_only_in_pulse) else $error("stray low");

    property p_width_two;
        @(posedge clk_i) disable iff (!rst_n_i)
        state_reg == ready_pulse_pkg::ST_PULSE |-> width_cnt_reg < 4'h2;
    endproperty
    a_width_two: assert property (p_width_two) else $error("width count overrun");

    property p_window_on_sample;
        @(posedge clk_i) disable iff (!rst_n_i)
        window_end |-> tick.sample_tick && tick.analog_phase == 4'h3;
    endproperty
    a_window_on_sample: assert property (p_window_on_sample) else $error("window off boundary");

    property p_rate_toggle;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && window_end) |=> output_rate_clock_o != $past(output_rate_clock_o);
    endproperty
    a_rate_toggle: assert property (p_rate_toggle) else $error("rate clock stuck");

    // Rate clock moves only at a window end
    property p_rate_steady;
        @(posedge clk_i) disable iff (!rst_n_i)
        !window_end |=> output_rate_clock_o == $past(output_rate_clock_o);
    endproperty
    a_rate_steady: assert property (p_rate_steady) else $error("rate clock moved");

    // Sample period is four prescaled master periods; skipped across a change
    property p_sample_gap;
        @(posedge clk_i) disable iff (!rst_n_i)
        (tick.sample_tick && gap_valid_reg && gap_prescale_reg == prescale_reg) |->
            sample_gap_reg == 6'((6'h04 << prescale_reg) - 6'h01);
    endproperty
    a_sample_gap: assert property (p_sample_gap) else $error("sample period wrong");

    // Every low pulse lasts two prescaled analog periods of enabled cycles
    property p_low_length;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(conversion_ready_strobe_n_o) |-> low_len_reg == (6'h02 << prescale_reg);
    endproperty
    a_low_length: assert property (p_low_length) else $error("pulse width wrong");
endmodule

/* tb/irq_host_model.sv */
module irq_host_model (
    // Clock
    input wire logic clk_i,
    // Ready pin as driven by the block
    input wire logic strobe_n_i,
    input wire logic oe_i,
    // Observations
    output logic pin_o,
    output int fall_count_o,
    output int period_o,
    output int width_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc;
    int fall_at;
    // Counters start at zero; edge detector starts at the pulled-up level
    logic prev = 1'b1;
    // Released pin pulled up on the board
    assign pin_o = oe_i ? strobe_n_i : 1'b1;
    // Sampled on the falling edge, away from the block's updates
    always @(negedge clk_i) begin
        cyc <= cyc + 1;
        prev <= pin_o;
        if (prev && !pin_o) begin
            fall_count_o <= fall_count_o + 1;
            period_o <= cyc - fall_at;
            fall_at <= cyc;
        end
        if (!prev && pin_o) begin
            width_o <= cyc - fall_at;
        end
    end
endmodule

/* tb/conversion_ready_pulse_gen_tb_top.sv */
`define CHECK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s: expected %0h seen %0h", n, e, g); end end
module conversion_ready_pulse_gen_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic drive_sel = 1'h0;
    logic [1:0] prescale_sel = 2'h0;
    logic [2:0] osr_sel = 3'h0;
    logic strobe_n, strobe_oe, rate_clk, pin;
    int fall_count, period, width, fail_count = 0, checked = 0, cycles = 0;
    conversion_ready_pulse_gen dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .ready_pin_drive_select_i(drive_sel), .prescale_sel_i(prescale_sel),
        .osr_sel_i(osr_sel), .conversion_ready_strobe_n_o(strobe_n),
        .conversion_ready_strobe_oe_o(strobe_oe), .output_rate_clock_o(rate_clk));
    irq_host_model host (.clk_i(clk_i), .strobe_n_i(strobe_n), .oe_i(strobe_oe), .pin_o(pin),
        .fall_count_o(fall_count), .period_o(period), .width_o(width));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // Whole run needs about 55k cycles; ceiling leaves margin
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        `CHECK("reset strobe", 1'b1, strobe_n)
        `CHECK("reset oe", 1'b0, strobe_oe)
        `CHECK("reset rate", 1'b0, rate_clk)
        @(posedge clk_i);
        rst_n_i <= 1'b1;
    endtask
    task automatic wait_fall();
        int target;
        target = fall_count + 1;
        for (int n = 0; n < 20000 && fall_count != target; n++) begin
            @(negedge clk_i);
        end
        `CHECK("pulse seen", target, fall_count)
    endtask
    // Every prescale and four oversampling ratios, both idle modes
    task automatic test_rates();
        int p;
        logic r0;
        for (int i = 0; i < 4; i++) begin
            p = 1 << i;
            @(posedge clk_i);
            prescale_sel <= 2'(i);
            osr_sel <= 3'(i);
            drive_sel <= i[0];
            do_reset();
            wait_fall();
            r0 = rate_clk;
            wait_fall();
            `CHECK("period", 4 * p * (32 << i), period)
            `CHECK("rate toggle", ~r0, rate_clk)
            // Width is only known once this pulse has ended
            repeat (2 * p + 2) @(negedge clk_i);
            `CHECK("width", 2 * p, width)
            `CHECK("idle pin", 1'b1, pin)
            `CHECK("idle oe", i[0], strobe_oe)
        end
    endtask
    // Frozen clock enable stretches the period by the frozen cycles
    task automatic test_freeze();
        @(posedge clk_i);
        prescale_sel <= 2'h0;
        osr_sel <= 3'h0;
        drive_sel <= 1'h1;
        do_reset();
        wait_fall();
        wait_fall();
        @(posedge clk_i);
        ce_i <= 1'b0;
        repeat (100) @(posedge clk_i);
        ce_i <= 1'b1;
        wait_fall();
        `CHECK("frozen period", 128 + 100, period)
    endtask
    // Upper oversampling codes at divide by one, changed live after a pulse
    task automatic test_osr_live();
        @(posedge clk_i);
        prescale_sel <= 2'h0;
        osr_sel <= 3'h4;
        drive_sel <= 1'h0;
        do_reset();
        wait_fall();
        for (int s = 4; s < 8; s++) begin
            @(posedge clk_i);
            osr_sel <= 3'(s);
            wait_fall();
            `CHECK("osr period", 4 * (32 << s), period)
        end
    endtask
    initial begin
        test_rates();
        test_freeze();
        test_osr_live();
        end_sim();
    end
endmodule
